// File: dv/plsl_neighbour.sv
`timescale 1ns/1ns
// companion slice read-only port: mirrors writes forwarded by its partner
module plsl_neighbour
   import plsl_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // write path forwarded from the read-write slice
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [1:0]        wr_data,
   // independent read port
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [1:0]        rd_data
);
   logic [1:0] mem_reg  [TABLE_WORDS];
   logic [1:0] mem_next [TABLE_WORDS];
   // write lands at the edge only, so a same-cycle read sees old data
   always_comb begin
      mem_next = mem_reg;
      if (wr_en) begin
         mem_next[wr_addr] = wr_data;
      end
   end
   // contents register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_reg <= '{default: 2'h0};
      end else begin
         mem_reg <= mem_next;
      end
   end
   assign rd_data = mem_reg[rd_addr];
endmodule : plsl_neighbour

// File: dv/test_plsl_slice.sv
`timescale 1ns/1ns
// random fabric traffic and bus accesses checked against a bench model
module test_plsl_slice
   import plsl_pkg::*;
();
   typedef struct packed {
      logic [1:0] byp, q, pd;
      logic [2:0] cmp;
      logic [3:0] wa;
      logic       wlo, whi, co, g, p, we, cb, cw, cg, cp;
   } plsl_exp_type;
   logic          clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, wbwe = 1'h0;
   logic [7:0]    adr = 8'h00;
   logic [3:0]    sel = 4'h0, til = 4'h0, tih = 4'h0, wad = 4'h0, wao;
   logic [31:0]   wdat = 32'h0, rdat, rdat2, seed = 32'h0000C89E, r;
   logic          m0 = 1'h0, m1 = 1'h0, ce = 1'h0, local_set_clear = 1'h0, cin = 1'h0;
   logic          wl = 1'h0, wh = 1'h0, wen = 1'h0, comp = 1'h0;
   logic [1:0]    wd = 2'h0, byp, q, pdat, setv = 2'h0, qm = 2'h0;
   logic          ack, ack2, weo, weo2, wlo_o, whi_o, co_o, g_o, p_o;
   logic [2:0]    cmp;
   logic [15:0]   lo_t = 16'h0, hi_t = 16'h0, pv = 16'h0;
   logic [1:0]    pm [16];
   plsl_mode_type mode = MODE_LOGIC;
   plsl_op_type   op = OP_ADD;
   plsl_exp_type  fq [$];
   plsl_exp_type  x;
   logic [31:0]   rq [$], rq2 [$], e1, e2, mk;
   int            bad_count = 0, tests_run = 0;

   plsl_slice plsl_slice_inst (.CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(wbwe), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .TABLE_IN_LOW(til), .TABLE_IN_HIGH(tih), .MULTIPURPOSE_IN_LOW(m0),
      .MULTIPURPOSE_IN_HIGH(m1), .CLOCK_ENABLE(ce), .LOCAL_SET_CLEAR(local_set_clear),
      .CARRY_CHAIN_IN(cin), .WIDE_IN_LOW(wl), .WIDE_IN_HIGH(wh), .MEM_WRITE_EN(wen),
      .MEM_WRITE_ADDR(wad), .MEM_WRITE_DATA(wd), .MEM_WRITE_EN_OUT(weo),
      .MEM_WRITE_ADDR_OUT(wao), .TABLE_BYPASS_OUTPUTS(byp), .REGISTERED_OUTPUTS(q),
      .WIDE_MUX_OUT_LOW(wlo_o), .WIDE_MUX_OUT_HIGH(whi_o), .CARRY_CHAIN_OUT(co_o),
      .CARRY_GENERATE(g_o), .CARRY_PROPAGATE(p_o), .COMPARE_GE_NE_LE(cmp));
   // variant without ram sees the same stimulus
   plsl_slice #(.HAS_RAM(1'h0)) plsl_slice_norom_inst (.CLK(clk), .SYS_RST(rst),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wbwe), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat2), .WB_ACK_O(ack2), .TABLE_IN_LOW(til),
      .TABLE_IN_HIGH(tih), .MULTIPURPOSE_IN_LOW(m0), .MULTIPURPOSE_IN_HIGH(m1),
      .CLOCK_ENABLE(ce), .LOCAL_SET_CLEAR(local_set_clear), .CARRY_CHAIN_IN(cin), .WIDE_IN_LOW(wl),
      .WIDE_IN_HIGH(wh), .MEM_WRITE_EN(wen), .MEM_WRITE_ADDR(wad), .MEM_WRITE_DATA(wd),
      .MEM_WRITE_EN_OUT(weo2), .MEM_WRITE_ADDR_OUT(), .TABLE_BYPASS_OUTPUTS(),
      .REGISTERED_OUTPUTS(), .WIDE_MUX_OUT_LOW(), .WIDE_MUX_OUT_HIGH(), .CARRY_CHAIN_OUT(),
      .CARRY_GENERATE(), .CARRY_PROPAGATE(), .COMPARE_GE_NE_LE());
   plsl_neighbour plsl_neighbour_inst (.clk(clk), .rst(rst), .wr_en(weo), .wr_addr(wao),
      .wr_data(wd), .rd_addr(tih), .rd_data(pdat));

   // 250 MHz clock
   always #2 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'h1) begin
         $display("Error at %0t: %s mismatch", $time, m);
         bad_count++;
      end
   endtask : chk

   task automatic complete_run();
      $display("Counts: %0d checks, %0d errors", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // classic cycle: hold everything until ack is sampled, then idle a cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, input logic [31:0] e, input logic [31:0] f);
      int n;
      n = 0;
      if (!w) begin
         rq.push_back(e);
         rq2.push_back(f);
      end
      cyc <= 1'h1;
      stb <= 1'h1;
      wbwe <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'h1 && n < 20);
      if (n >= 20) chk(1'h0, "bus timeout");
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
   endtask : wb

   // one random fabric cycle; quiet holds enables, set/clear and writes low
   task automatic step(input logic quiet);
      plsl_exp_type e;
      logic [31:0]  v;
      logic [1:0]   a, b, bb, f;
      logic [2:0]   s;
      logic         rip, lv, cv;
      v = rnd();
      rip = (mode == MODE_RIPPLE);
      a = {v[4], v[0]};
      b = {v[5], v[1]};
      f = {hi_t[(mode == MODE_RAM) ? v[3:0] : v[7:4]], lo_t[v[3:0]]};
      case (op)
         OP_SUB: bb = ~b;
         OP_ADDSUB: bb = v[8] ? b : ~b;
         OP_MULT: bb = b & {2{v[9]}};
         default: bb = b;
      endcase
      s = {1'h0, a} + {1'h0, bb} + {2'h0, v[10]};
      if (op == OP_UPCNT) s = {1'h0, qm} + {2'h0, v[10]};
      if (op == OP_DNCNT) s = {1'h1, qm} - {2'h0, v[10]};
      e = '0;
      e.byp = rip ? s[1:0] : f;
      e.co = rip ? s[2] : v[10];
      e.cb = !(rip && op == OP_CMP);
      e.cg = rip && (op == OP_ADD || op == OP_SUB || op == OP_ADDSUB || op == OP_MULT);
      e.g = ({1'h0, a} + {1'h0, bb}) > 3'h3;
      e.p = ({1'h0, a} + {1'h0, bb}) == 3'h3;
      e.cmp = rip ? {a >= b, a != b, a <= b} : 3'h0;
      e.cw = (mode == MODE_LOGIC);
      e.wlo = v[8] ? f[1] : f[0];
      e.whi = v[9] ? v[12] : v[11];
      e.we = (mode == MODE_RAM) && v[13] && !quiet;
      e.wa = comp ? v[24:21] : v[3:0];
      e.q = qm;
      e.cp = pv[v[7:4]];
      e.pd = pm[v[7:4]];
      fq.push_back(e);
      lv = (v[19:16] == 4'h0) && !quiet;
      cv = v[20] && !quiet && e.cb;
      qm = lv ? setv : (cv ? e.byp : qm);
      if (e.we) begin
         lo_t[e.wa] = v[14];
         hi_t[e.wa] = v[15];
         pm[e.wa] = v[15:14];
         pv[e.wa] = 1'h1;
      end
      til <= v[3:0];
      tih <= v[7:4];
      m0 <= v[8];
      m1 <= v[9];
      cin <= v[10];
      wl <= v[11];
      wh <= v[12];
      wen <= v[13] && !quiet;
      wd <= v[15:14];
      local_set_clear <= lv;
      ce <= cv;
      wad <= v[24:21];
      @(posedge clk);
   endtask : step

   task automatic setup(input plsl_mode_type m, input plsl_op_type o, input int n);
      r = rnd();
      setv = r[1:0];
      mode = m;
      op = o;
      wb(1'h1, OFS_CTRL, 4'h1, {24'h0, comp, setv, o, m}, 32'h0, 32'h0);
      repeat (n) step(1'h0);
      step(1'h1);
   endtask : setup

   // read answers are judged at the ack edge; status of the variant differs
   always @(posedge clk) begin
      if (ack === 1'h1 && wbwe === 1'h0 && rq.size() > 0) begin
         e1 = rq.pop_front();
         e2 = rq2.pop_front();
         mk = (adr == OFS_STATUS) ? 32'h0000_002F : 32'hFFFF_FFFF;
         chk((rdat & mk) === (e1 & mk), "read data");
         mk = (adr == OFS_STATUS) ? 32'h0000_0023 : mk;
         chk(ack2 === 1'h1 && (rdat2 & mk) === (e2 & mk), "variant read");
      end
   end

   // fabric outputs are settled by mid-cycle
   always @(negedge clk) begin
      if (fq.size() > 0) begin
         x = fq.pop_front();
         chk(q === x.q, "registered output");
         if (x.cb) chk(byp === x.byp, "bypass");
         if (x.cb) chk(co_o === x.co, "carry out");
         if (x.cg) chk({g_o, p_o} === {x.g, x.p}, "generate propagate");
         chk(cmp === x.cmp, "compare flags");
         if (x.cw) chk(wlo_o === x.wlo, "five input");
         if (x.cw) chk(whi_o === x.whi, "wide high");
         chk(weo === x.we && weo2 === 1'h0, "write forward");
         if (x.we) chk(wao === x.wa, "write address");
         if (x.cp) chk(pdat === x.pd, "companion read");
      end
   end

   // watchdog sized well beyond the roughly 2.4 us of traffic
   initial begin
      #20000;
      chk(1'h0, "watchdog");
      complete_run();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      wb(1'h0, OFS_CTRL, 4'hF, 32'h0, CTRL_RESET, CTRL_RESET);
      wb(1'h0, OFS_TABLE, 4'hF, 32'h0, 32'h0, 32'h0);
      wb(1'h0, OFS_STATUS, 4'hF, 32'h0, 32'h0000_0020, 32'h0);
      wb(1'h1, 8'h0C, 4'hF, 32'hFFFF_FFFF, 32'h0, 32'h0);
      wb(1'h0, 8'h0C, 4'hF, 32'h0, 32'h0, 32'h0);
      wb(1'h1, OFS_CTRL, 4'hE, 32'h0000_00FF, 32'h0, 32'h0);
      wb(1'h0, OFS_CTRL, 4'hF, 32'h0, CTRL_RESET, CTRL_RESET);
      r = rnd();
      lo_t = r[15:0];
      hi_t = r[31:16];
      wb(1'h1, OFS_TABLE, 4'hF, r, 32'h0, 32'h0);
      wb(1'h0, OFS_TABLE, 4'hF, 32'h0, r, r);
      setup(MODE_LOGIC, OP_ADD, 60);
      setup(MODE_RAM, OP_ADD, 80);
      wb(1'h0, OFS_STATUS, 4'hF, 32'h0, {26'h0, 1'h1, 1'h0, qm, 2'h2}, 32'h3);
      // companion run: writes follow the forwarded address, reads stay local
      comp = 1'h1;
      setup(MODE_RAM, OP_ADD, 40);
      comp = 1'h0;
      setup(MODE_ROM, OP_ADD, 60);
      setup(MODE_RIPPLE, OP_ADD, 40);
      setup(MODE_RIPPLE, OP_SUB, 40);
      setup(MODE_RIPPLE, OP_ADDSUB, 40);
      setup(MODE_RIPPLE, OP_UPCNT, 40);
      setup(MODE_RIPPLE, OP_DNCNT, 40);
      setup(MODE_RIPPLE, OP_MULT, 40);
      setup(MODE_RIPPLE, OP_CMP, 40);
      complete_run();
   end
endmodule : test_plsl_slice

// File: hdl/plsl_arith.sv
`timescale 1ns/1ns
// two-bit ripple unit, purely combinational
module plsl_arith
   import plsl_pkg::*;
(
   // operation select
   input  plsl_op_type    op,
   input  wire logic      dyn_add,
   input  wire logic      mult_en,
   // operands and chain
   input  wire logic [1:0] a,
   input  wire logic [1:0] b,
   input  wire logic [1:0] q,
   input  wire logic       cin,
   // result
   output plsl_arith_type res
);
   // two-bit add with carry: {carry, sum}
   function automatic logic [2:0] add2(input logic [1:0] x, input logic [1:0] y,
                                       input logic c);
      add2 = {1'b0, x} + {1'b0, y} + {2'h0, c};
   endfunction : add2

   logic [1:0] opa;
   logic [1:0] opb;
   logic [2:0] total;
   logic [2:0] nocarry;

   // second operand per function
   always_comb begin
      opb = b;
      case (op)
         OP_ADD:    opb = b;
         OP_SUB:    opb = ~b;
         OP_ADDSUB: opb = dyn_add ? b : ~b;
         OP_UPCNT:  opb = 2'h0;
         OP_DNCNT:  opb = 2'h3;
         OP_MULT:   opb = b & {2{mult_en}};
         OP_CMP:    opb = ~b;
         default:   opb = b;
      endcase
   end

   // counters run on the registered value, the rest on operand a
   always_comb begin
      opa = (op == OP_UPCNT || op == OP_DNCNT) ? q : a;
      if (op == OP_UPCNT) begin
         total   = add2(q, opb, cin);
         nocarry = add2(q, opb, 1'b0);
      end else if (op == OP_DNCNT) begin
         total   = add2(q, opb, ~cin);
         nocarry = add2(q, opb, 1'b0);
      end else begin
         total   = add2(a, opb, cin);
         nocarry = add2(a, opb, 1'b0);
      end
      res.sum  = total[1:0];
      res.cout = total[2];
      res.gen  = nocarry[2];
      res.prop = &(opa ^ opb);
      res.ge   = (a >= b);
      res.ne   = (a != b);
      res.le   = (a <= b);
   end
endmodule : plsl_arith

// File: hdl/plsl_pkg.sv
package plsl_pkg;
   // register byte offsets on the bus
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_TABLE     = 8'h04;
   localparam logic [7:0]  OFS_STATUS    = 8'h08;
   // control field positions
   localparam int          CTRL_MODE_LSB = 0;
   localparam int          CTRL_OP_LSB   = 2;
   localparam int          CTRL_SET_LSB  = 5;
   localparam int          CTRL_COMP_BIT = 7;
   // table register: low table in low half, high table in high half
   localparam int          TABLE_HI_LSB  = 16;
   // status field positions
   localparam int          STAT_MODE_LSB = 0;
   localparam int          STAT_Q_LSB    = 2;
   localparam int          STAT_CO_BIT   = 4;
   localparam int          STAT_RAM_BIT  = 5;
   // reset values
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [15:0] TABLE_RESET   = 16'h0000;
   localparam logic [1:0]  OUT_RESET     = 2'h0;
   // geometry
   localparam int          TABLE_WORDS   = 16;
   localparam int          ADDR_W        = 4;

   typedef enum logic [1:0] {
      MODE_LOGIC, MODE_RIPPLE, MODE_RAM, MODE_ROM
   } plsl_mode_type;

   typedef enum logic [2:0] {
      OP_ADD, OP_SUB, OP_ADDSUB, OP_UPCNT, OP_DNCNT, OP_MULT, OP_CMP
   } plsl_op_type;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } plsl_wb_req_type;

   typedef struct packed {
      logic [1:0] sum;
      logic       cout;
      logic       gen;
      logic       prop;
      logic       ge;
      logic       ne;
      logic       le;
   } plsl_arith_type;
endpackage : plsl_pkg

// File: hdl/plsl_slice.sv
`timescale 1ns/1ns
module plsl_slice
   import plsl_pkg::*;
#(
   parameter bit HAS_RAM = 1'b1
)(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O,
   // table inputs and multipurpose inputs
   input  wire logic [3:0]  TABLE_IN_LOW,
   input  wire logic [3:0]  TABLE_IN_HIGH,
   input  wire logic        MULTIPURPOSE_IN_LOW,
   input  wire logic        MULTIPURPOSE_IN_HIGH,
   // register control
   input  wire logic        CLOCK_ENABLE,
   input  wire logic        LOCAL_SET_CLEAR,
   // chain and neighbour wide results
   input  wire logic        CARRY_CHAIN_IN,
   input  wire logic        WIDE_IN_LOW,
   input  wire logic        WIDE_IN_HIGH,
   // memory write port, shared with a companion slice
   input  wire logic        MEM_WRITE_EN,
   input  wire logic [3:0]  MEM_WRITE_ADDR,
   input  wire logic [1:0]  MEM_WRITE_DATA,
   output logic             MEM_WRITE_EN_OUT,
   output logic [3:0]       MEM_WRITE_ADDR_OUT,
   // data outputs
   output logic [1:0]       TABLE_BYPASS_OUTPUTS,
   output logic [1:0]       REGISTERED_OUTPUTS,
   output logic             WIDE_MUX_OUT_LOW,
   output logic             WIDE_MUX_OUT_HIGH,
   output logic             CARRY_CHAIN_OUT,
   output logic             CARRY_GENERATE,
   output logic             CARRY_PROPAGATE,
   output logic [2:0]       COMPARE_GE_NE_LE
);
   plsl_wb_req_type        req;
   logic                   ack_reg;
   logic                   ack_next;
   logic [31:0]            rdat_reg;
   logic [31:0]            rdat_next;
   logic [31:0]            ctrl_reg;
   logic [31:0]            ctrl_next;
   logic [1:0]             q_reg;
   logic [1:0]             q_next;
   logic                   wr_ctrl;
   logic                   ld_table;
   plsl_mode_type          mode_cfg;
   plsl_mode_type          mode;
   plsl_op_type            op;
   logic [1:0]             set_val;
   logic                   companion;
   logic [TABLE_WORDS-1:0] tab_lo;
   logic [TABLE_WORDS-1:0] tab_hi;
   logic [TABLE_WORDS-1:0] rb_lo;
   logic [TABLE_WORDS-1:0] rb_hi;
   logic                   user_wr;
   logic [3:0]             user_addr;
   logic [1:0]             lut_out;
   logic [1:0]             f_out;
   plsl_arith_type         ar;

   // a table lookup used by both tables
   function automatic logic lookup(input logic [TABLE_WORDS-1:0] t, input logic [3:0] i);
      lookup = t[i];
   endfunction : lookup

   assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                  sel: WB_SEL_I, dat: WB_DAT_I};

   // configuration fields
   assign mode_cfg  = plsl_mode_type'(ctrl_reg[CTRL_MODE_LSB +: 2]);
   assign op        = plsl_op_type'(ctrl_reg[CTRL_OP_LSB +: 3]);
   assign set_val   = ctrl_reg[CTRL_SET_LSB +: 2];
   assign companion = ctrl_reg[CTRL_COMP_BIT];

   // without write capability the ram setting reads as rom
   always_comb begin
      mode = mode_cfg;
      if (!HAS_RAM && mode_cfg == MODE_RAM) begin
         mode = MODE_ROM;
      end
   end

   // bus: ack one cycle after the request; writes land on the ack edge
   always_comb begin
      ack_next  = req.cyc && req.stb && !ack_reg;
      rdat_next = rdat_reg;
      wr_ctrl   = req.cyc && req.stb && req.we && ack_reg && req.adr == OFS_CTRL;
      ld_table  = req.cyc && req.stb && req.we && ack_reg && req.adr == OFS_TABLE;
      ctrl_next = ctrl_reg;
      if (wr_ctrl && req.sel[0]) begin
         ctrl_next[7:0] = req.dat[7:0];
      end
      if (req.cyc && req.stb && !ack_reg) begin
         case (req.adr)
            OFS_CTRL:   rdat_next = ctrl_reg;
            OFS_TABLE:  rdat_next = {rb_hi, rb_lo};
            OFS_STATUS: begin
               rdat_next = 32'h0000_0000;
               rdat_next[STAT_MODE_LSB +: 2] = mode;
               rdat_next[STAT_Q_LSB +: 2]    = q_reg;
               rdat_next[STAT_CO_BIT]        = CARRY_CHAIN_OUT;
               rdat_next[STAT_RAM_BIT]       = HAS_RAM;
            end
            default:    rdat_next = 32'h0000_0000;      // unmapped reads as zero
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
         ctrl_reg <= CTRL_RESET;
      end else begin
         ack_reg  <= ack_next;
         rdat_reg <= rdat_next;
         ctrl_reg <= ctrl_next;
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdat_reg;

   // user write only in ram mode; a companion follows its partner's address
   assign user_wr   = (mode == MODE_RAM) && MEM_WRITE_EN;
   assign user_addr = companion ? MEM_WRITE_ADDR : TABLE_IN_LOW;
   assign MEM_WRITE_EN_OUT   = user_wr;
   assign MEM_WRITE_ADDR_OUT = user_addr;

   // table load: table bits are only loadable as a full 16-bit half
   plsl_table_mem u_tab_lo (
      .clk       (CLK),
      .rst       (SYS_RST),
      .load_en   (ld_table && (&req.sel[1:0])),
      .load_data (req.dat[TABLE_WORDS-1:0]),
      .wr_en     (user_wr),
      .wr_addr   (user_addr),
      .wr_bit    (MEM_WRITE_DATA[0]),
      .contents  (tab_lo),
      .readback  (rb_lo)
   );

   plsl_table_mem u_tab_hi (
      .clk       (CLK),
      .rst       (SYS_RST),
      .load_en   (ld_table && (&req.sel[3:2])),
      .load_data (req.dat[TABLE_HI_LSB +: TABLE_WORDS]),
      .wr_en     (user_wr),
      .wr_addr   (user_addr),
      .wr_bit    (MEM_WRITE_DATA[1]),
      .contents  (tab_hi),
      .readback  (rb_hi)
   );

   // ram reads both tables at one address; other modes index each table
   always_comb begin
      if (mode == MODE_RAM) begin
         lut_out[0] = lookup(tab_lo, TABLE_IN_LOW);
         lut_out[1] = lookup(tab_hi, TABLE_IN_LOW);
      end else begin
         lut_out[0] = lookup(tab_lo, TABLE_IN_LOW);
         lut_out[1] = lookup(tab_hi, TABLE_IN_HIGH);
      end
   end

   // ripple unit operands: a from the first input pins, b from the second
   plsl_arith u_arith (
      .op      (op),
      .dyn_add (MULTIPURPOSE_IN_LOW),
      .mult_en (MULTIPURPOSE_IN_HIGH),
      .a       ({TABLE_IN_HIGH[0], TABLE_IN_LOW[0]}),
      .b       ({TABLE_IN_HIGH[1], TABLE_IN_LOW[1]}),
      .q       (q_reg),
      .cin     (CARRY_CHAIN_IN),
      .res     (ar)
   );

   // bypass results; combinational so chains do not lose a cycle
   always_comb begin
      f_out = lut_out;
      if (mode == MODE_RIPPLE) begin
         f_out = ar.sum;
      end
   end
   assign TABLE_BYPASS_OUTPUTS = f_out;

   // carry chain is only live in ripple mode, else passes the neighbour on
   assign CARRY_CHAIN_OUT  = (mode == MODE_RIPPLE) ? ar.cout : CARRY_CHAIN_IN;
   assign CARRY_GENERATE   = (mode == MODE_RIPPLE) && ar.gen;
   assign CARRY_PROPAGATE  = (mode == MODE_RIPPLE) && ar.prop;
   assign COMPARE_GE_NE_LE = (mode == MODE_RIPPLE) ? {ar.ge, ar.ne, ar.le} : 3'h0;

   // wide functions
   assign WIDE_MUX_OUT_LOW  = MULTIPURPOSE_IN_LOW ? lut_out[1] : lut_out[0];
   assign WIDE_MUX_OUT_HIGH = MULTIPURPOSE_IN_HIGH ? WIDE_IN_HIGH : WIDE_IN_LOW;

   // output registers: set/clear beats clock enable
   always_comb begin
      q_next = q_reg;
      if (LOCAL_SET_CLEAR) begin
         q_next = set_val;
      end else if (CLOCK_ENABLE) begin
         q_next = f_out;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         q_reg <= OUT_RESET;
      end else begin
         q_reg <= q_next;
      end
   end
   assign REGISTERED_OUTPUTS = q_reg;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   property p_mode_sel;
      (!HAS_RAM && mode_cfg == MODE_RAM) ? (mode == MODE_ROM) : (mode == mode_cfg);
   endproperty
   a_mode_sel: assert property (p_mode_sel) else $error("mode differs from setting");

   property p_no_ram;
      !HAS_RAM |-> !user_wr && mode != MODE_RAM;
   endproperty
   a_no_ram: assert property (p_no_ram) else $error("ram active in ramless slice");

   property p_logic_lookup;
      mode == MODE_LOGIC |-> TABLE_BYPASS_OUTPUTS ==
         {tab_hi[TABLE_IN_HIGH], tab_lo[TABLE_IN_LOW]};
   endproperty
   a_logic_lookup: assert property (p_logic_lookup) else $error("logic lookup wrong");

   property p_wide_low;
      mode != MODE_RAM |-> WIDE_MUX_OUT_LOW ==
         (MULTIPURPOSE_IN_LOW ? tab_hi[TABLE_IN_HIGH] : tab_lo[TABLE_IN_LOW]);
   endproperty
   a_wide_low: assert property (p_wide_low) else $error("five-input mux wrong");

   property p_add;
      mode == MODE_RIPPLE && op == OP_ADD |-> {CARRY_CHAIN_OUT, TABLE_BYPASS_OUTPUTS} ==
         {1'h0, TABLE_IN_HIGH[0], TABLE_IN_LOW[0]} + {1'h0, TABLE_IN_HIGH[1], TABLE_IN_LOW[1]}
            + {2'h0, CARRY_CHAIN_IN};
   endproperty
   a_add: assert property (p_add) else $error("ripple add wrong");

   property p_upcount;
      mode == MODE_RIPPLE && op == OP_UPCNT && CARRY_CHAIN_IN && CLOCK_ENABLE
         && !LOCAL_SET_CLEAR |=> REGISTERED_OUTPUTS == 2'($past(q_reg) + 2'h1);
   endproperty
   a_upcount: assert property (p_upcount) else $error("up count wrong");

   property p_ram_write;
      user_wr && !ld_table |=> tab_lo[$past(user_addr)] == $past(MEM_WRITE_DATA[0])
         && tab_hi[$past(user_addr)] == $past(MEM_WRITE_DATA[1]);
   endproperty
   a_ram_write: assert property (p_ram_write) else $error("ram write lost");

   property p_set_clear;
      LOCAL_SET_CLEAR |=> REGISTERED_OUTPUTS == $past(set_val);
   endproperty
   a_set_clear: assert property (p_set_clear) else $error("set/clear ignored");

   property p_hold;
      !LOCAL_SET_CLEAR && !CLOCK_ENABLE |=> $stable(REGISTERED_OUTPUTS);
   endproperty
   a_hold: assert property (p_hold) else $error("register moved without enable");

   property p_ack;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack timing wrong");

   c_ripple: cover property (mode == MODE_RIPPLE && CARRY_CHAIN_OUT);
   c_ram:    cover property (user_wr ##1 mode == MODE_RAM);
   c_setclr: cover property (LOCAL_SET_CLEAR && CLOCK_ENABLE);
   c_wide:   cover property (MULTIPURPOSE_IN_LOW && WIDE_MUX_OUT_LOW);
endmodule : plsl_slice

// File: hdl/plsl_table_mem.sv
`timescale 1ns/1ns
// one 16x1 table: loaded whole from the bus, written bitwise in ram mode
module plsl_table_mem
   import plsl_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // configuration load
   input  wire logic                   load_en,
   input  wire logic [TABLE_WORDS-1:0] load_data,
   // user write port
   input  wire logic                   wr_en,
   input  wire logic [ADDR_W-1:0]      wr_addr,
   input  wire logic                   wr_bit,
   // contents for the combinational lookup and registered read-back
   output logic [TABLE_WORDS-1:0]      contents,
   output logic [TABLE_WORDS-1:0]      readback
);
   logic [TABLE_WORDS-1:0] mem_reg;
   logic [TABLE_WORDS-1:0] mem_next;
   logic [TABLE_WORDS-1:0] rb_reg;

   // user write lands after the load so it wins on its own bit
   always_comb begin
      mem_next = mem_reg;
      if (load_en) begin
         mem_next = load_data;
      end
      if (wr_en) begin
         mem_next[wr_addr] = wr_bit;
      end
   end

   // storage and read-back register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_reg <= TABLE_RESET;
         rb_reg  <= TABLE_RESET;
      end else begin
         mem_reg <= mem_next;
         rb_reg  <= mem_reg;
      end
   end

   assign contents = mem_reg;
   assign readback = rb_reg;
endmodule : plsl_table_mem
